// File: bench/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [63:0] i_line_tx,
  input  wire logic        i_corrupt,
  input  wire logic        i_marker_send,
  input  wire logic [7:0]  i_marker_byte,
  output logic      [63:0] o_line_rx,
  output logic             o_line_valid,
  output logic             o_marker_seen,
  output logic      [7:0]  o_marker_byte
);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_line_rx     <= 64'h0;
      o_line_valid  <= 1'b0;
      o_marker_seen <= 1'b0;
      o_marker_byte <= 8'h00;
    end else begin
      o_line_rx     <= i_corrupt ? (i_line_tx ^ 64'h1) : i_line_tx;
      o_line_valid  <= 1'b1;
      o_marker_seen <= i_marker_send;
      // stale byte toggles so it is never mistaken for valid
      o_marker_byte <= i_marker_send ? i_marker_byte : ~o_marker_byte;
    end
  end
endmodule : link_partner_model

// File: bench/pcs_lane_test_and_marker_status_tb.sv
`timescale 1ns/1ps
module pcs_lane_test_and_marker_status_tb;
  import pcs_lane_pkg::*;
  localparam int WIN = 32;
  logic i_clock = 0, i_rst_b = 0, cyc = 0, stb = 0, we = 0, irq, sos = 0;
  logic [7:0] adr = 0, mk_byte = 0, txm = 0, mb, ob, rx_mb, tx_mb;
  logic [31:0] wdat = 0, rdat, e, m;
  logic [3:0] sel = 0;
  logic ack, hdr = 0, mode_pin = 1, mk_send = 0, corrupt = 0, rx_v, rx_seen;
  logic [13:0] lane = 0, lane_o, v;
  logic hib, osf, mkv, flt, mode_o;
  logic [2:0] incr;
  logic [63:0] txd = 0, tx_o, rx_d;
  int mismatches = 0, check_count = 0, sum;
  logic [31:0] rd_q[$], rm_q[$];
  logic [13:0] lane_q[$];
  logic [7:0] mk_q[$];
  always #20 i_clock = ~i_clock;
  ////////////////////////////////////////////////////////////////////////////
  pcs_lane_test_and_marker_status #(.BER_WINDOW_CYCLES(WIN),
    .BER_ERR_LIMIT(4)) u_pcs_lane_test_and_marker_status (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq),
    .i_rx_lane_bip_fail(lane), .i_rx_header_err(hdr),
    .i_rx_signal_os_word(sos), .i_rx_data(rx_d), .i_rx_data_valid(rx_v),
    .i_rx_marker_seen(rx_seen), .i_rx_marker_bip7(rx_mb),
    .i_tx_data(txd), .i_tx_marker_bip7(txm),
    .i_four_lane_mode_select(mode_pin), .o_lane_bip_err(lane_o),
    .o_high_error_rate_flag(hib), .o_signal_ordered_set_seen(osf),
    .o_tp_mismatch_incr(incr), .o_received_marker_parity_byte(tx_mb),
    .o_received_marker_parity_valid(mkv), .o_internal_local_fault(flt),
    .o_four_lane_mode(mode_o), .o_tx_data(tx_o), .o_tx_marker_bip7(ob));
  link_partner_model u_link_partner_model (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_line_tx(tx_o),
    .i_corrupt(corrupt), .i_marker_send(mk_send), .i_marker_byte(mk_byte),
    .o_line_rx(rx_d), .o_line_valid(rx_v), .o_marker_seen(rx_seen),
    .o_marker_byte(rx_mb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [63:0] exp,
                       input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // reads note the expected word and a mask of the bits that matter
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] msk);
    int n;
    @(posedge i_clock);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'h3;
    if (!w) begin
      rd_q.push_back(d);
      rm_q.push_back(msk);
    end
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check("wb ack", 1, 0);
    @(posedge i_clock);
    cyc <= 0; stb <= 0;
  endtask : wb
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge i_clock) begin
    if (ack === 1'b1 && !we) begin
      e = rd_q.pop_front();
      m = rm_q.pop_front();
      check("read data", e & m, rdat & m);
    end
    if (lane_o !== 14'h0) check("lane err", lane_q.pop_front(), lane_o);
    if (mkv === 1'b1) check("marker byte", mk_q.pop_front(), tx_mb);
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(83620));
    // mode pin is high from time zero and never moves
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1;
    wb(0, OFS_CTRL, 0, '1);
    wb(0, OFS_IRQ_MASK, 0, '1);
    wb(0, OFS_ERR_COUNT, 0, '1);
    wb(1, 8'h14, 32'hFFFF, 0);
    wb(0, 8'h14, 0, '1);
    wb(0, OFS_STATUS, 32'h8, 32'h8);
    @(negedge i_clock); check("mode", 1, mode_o);
    wb(1, OFS_IRQ_MASK, 32'h1, 0);
    for (int k = 0; k < 14; k++) begin
      @(posedge i_clock);
      v = (14'h1 << k) | 14'($urandom);
      lane <= v;
      lane_q.push_back(v);
    end
    @(posedge i_clock); lane <= 0;
    repeat (2) @(negedge i_clock); check("irq", 1, irq);
    wb(0, OFS_IRQ_STAT, 32'h1, 32'h1);
    repeat (2) @(negedge i_clock); check("irq clear", 0, irq);
    @(posedge i_clock); sos <= 1;
    @(posedge i_clock); sos <= 0;
    @(negedge i_clock); check("os seen", 1, osf);
    @(negedge i_clock); check("os pulse", 0, osf);
    wb(0, OFS_IRQ_STAT, 32'h2, 32'h2);
    mb = 8'($urandom);
    @(posedge i_clock); mk_send <= 1; mk_byte <= mb; mk_q.push_back(mb);
    @(posedge i_clock); mk_send <= 0;
    repeat (3) @(posedge i_clock);
    wb(0, OFS_STATUS, {16'h0, mb, 8'h10}, 32'hFF10);
    mb = 8'($urandom);
    txm <= 8'($urandom);
    // override byte held in its register while override is on
    wb(1, OFS_CTRL, {16'h0, mb, 8'h04}, 0);
    @(negedge i_clock); check("override", mb, ob);
    wb(1, OFS_CTRL, 0, 0);
    @(negedge i_clock); check("no override", txm, ob);
    @(posedge i_clock); txd <= {$urandom, $urandom};
    @(posedge i_clock);
    @(negedge i_clock); check("tx pass", txd, tx_o);
    @(posedge i_clock); corrupt <= 1;
    for (int k = 0; k < 6; k++) begin
      @(negedge i_clock); check("incr off", 0, incr);
    end
    @(posedge i_clock); corrupt <= 0;
    wb(1, OFS_CTRL, 32'h3, 0);
    repeat (2) @(negedge i_clock); check("fault tp", 1, flt);
    repeat (20) @(posedge i_clock);
    wb(1, OFS_ERR_COUNT, 0, 0);
    for (int k = 0; k < 20; k++) begin
      @(negedge i_clock); check("incr clean", 0, incr);
    end
    @(posedge i_clock); corrupt <= 1;
    @(posedge i_clock); corrupt <= 0;
    sum = 0;
    for (int k = 0; k < 8; k++) begin
      @(negedge i_clock); sum += int'(incr);
    end
    // one flipped line bit hits bits 0, 39 and 58: three 16-bit groups
    check("incr seen", 3, sum);
    wb(0, OFS_ERR_COUNT, 32'(sum), 32'hFFFF);
    wb(1, OFS_CTRL, 0, 0);
    repeat (4) @(negedge i_clock); check("fault off", 0, flt);
    @(posedge i_clock); hdr <= 1;
    repeat (2 * WIN) @(posedge i_clock);
    hdr <= 0;
    @(negedge i_clock); check("high ber", 1, hib);
    check("fault ber", 1, flt);
    wb(0, OFS_IRQ_STAT, 32'h4, 32'h4);
    repeat (3 * WIN) @(posedge i_clock);
    @(negedge i_clock); check("ber clear", 0, hib);
    check("notes left", 0, rd_q.size() + lane_q.size() + mk_q.size());
    finish_test();
  end
endmodule : pcs_lane_test_and_marker_status_tb

// File: rtl/idle_scrambler.sv
`timescale 1ns/1ps
module idle_scrambler #(
  parameter int W          = 64,
  parameter bit DESCRAMBLE = 1'b0
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic         i_clear,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_data,
  output logic      [W-1:0] o_data,
  output logic              o_valid
);
  import pcs_lane_pkg::*;

  typedef struct packed {
    logic [SCR_LEN-1:0] hist;
    logic [W-1:0]       data;
    logic               valid;
  } scr_t;

  scr_t state_reg;
  scr_t state_next;
  logic [W+SCR_LEN-1:0] ext;
  logic [W-1:0]         res;

  // self-synchronising polynomial x^58 + x^39 + 1, oldest bit lowest
  always_comb begin
    ext = '0;
    res = '0;
    ext[SCR_LEN-1:0] = state_reg.hist;
    for (int i = 0; i < W; i++) begin
      res[i] = i_data[i] ^ ext[SCR_LEN+i-SCR_TAP] ^ ext[i];
      ext[SCR_LEN+i] = DESCRAMBLE ? i_data[i] : res[i];
    end
    state_next       = state_reg;
    state_next.valid = 1'b0;
    if (i_clear) begin
      state_next = '0;
    end else if (i_en) begin
      state_next.hist  = ext[W+SCR_LEN-1:W];
      state_next.data  = res;
      state_next.valid = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_data  = state_reg.data;
  assign o_valid = state_reg.valid;
endmodule : idle_scrambler

// File: rtl/level_sync3.sv
`timescale 1ns/1ps
module level_sync3 (
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  input  wire logic i_async,
  output logic      o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_t;

  sync_t state_reg;
  sync_t state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.s1    = i_async;
    state_next.s2    = state_reg.s1;
    state_next.s3    = state_reg.s2;
    // a change counts only once the two later stages agree
    if (state_reg.s2 == state_reg.s3) begin
      state_next.level = state_reg.s3;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_level = state_reg.level;
endmodule : level_sync3

// File: rtl/pcs_lane_pkg.sv
package pcs_lane_pkg;
  localparam int          LANE_FIRST    = 6;
  localparam int          LANE_LAST     = 19;
  localparam int          LANE_COUNT    = LANE_LAST - LANE_FIRST + 1;
  localparam int          DATA_W        = 64;
  localparam int          GROUP_W       = 16;
  localparam int          SCR_LEN       = 58;
  localparam int          SCR_TAP       = 39;
  localparam logic [63:0] IDLE_WORD     = 64'h0000_0000_0000_001E;
  localparam int          BER_WINDOW    = 1024;
  localparam int          BER_LIMIT     = 16;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
  localparam logic [7:0]  OFS_ERR_COUNT = 8'h10;
  // control fields
  localparam int          CTRL_RX_TP    = 0;
  localparam int          CTRL_TX_TP    = 1;
  localparam int          CTRL_OVR_EN   = 2;
  localparam int          CTRL_OVR_LSB  = 8;
  localparam logic [7:0]  OVR_BYTE_RST  = 8'h00;
  // status fields
  localparam int          ST_HI_BER     = 0;
  localparam int          ST_SIG_OS     = 1;
  localparam int          ST_FAULT      = 2;
  localparam int          ST_FOUR_LANE  = 3;
  localparam int          ST_MK_VALID   = 4;
  localparam int          ST_MK_LSB     = 8;
  // interrupt fields
  localparam int          IRQ_W         = 5;
  localparam int          IRQ_BIP       = 0;
  localparam int          IRQ_SIG_OS    = 1;
  localparam int          IRQ_HI_BER    = 2;
  localparam int          IRQ_MISMATCH  = 3;
  localparam int          IRQ_MARKER    = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
endpackage : pcs_lane_pkg

// File: rtl/pcs_lane_test_and_marker_status.sv
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pcs_lane_test_and_marker_status #(
  parameter int BER_WINDOW_CYCLES = pcs_lane_pkg::BER_WINDOW,
  parameter int BER_ERR_LIMIT     = pcs_lane_pkg::BER_LIMIT
) (
  input  wire logic                                   i_clock,
  input  wire logic                                   i_rst_b,
  input  wire logic                                   i_wb_cyc,
  input  wire logic                                   i_wb_stb,
  input  wire logic                                   i_wb_we,
  input  wire logic [7:0]                             i_wb_adr,
  input  wire logic [31:0]                            i_wb_dat,
  input  wire logic [3:0]                             i_wb_sel,
  output logic      [31:0]                            o_wb_dat,
  output logic                                        o_wb_ack,
  output logic                                        o_irq,
  input  wire logic [pcs_lane_pkg::LANE_COUNT-1:0]    i_rx_lane_bip_fail,
  input  wire logic                                   i_rx_header_err,
  input  wire logic                                   i_rx_signal_os_word,
  input  wire logic [pcs_lane_pkg::DATA_W-1:0]        i_rx_data,
  input  wire logic                                   i_rx_data_valid,
  input  wire logic                                   i_rx_marker_seen,
  input  wire logic [7:0]                             i_rx_marker_bip7,
  input  wire logic [pcs_lane_pkg::DATA_W-1:0]        i_tx_data,
  input  wire logic [7:0]                             i_tx_marker_bip7,
  input  wire logic                                   i_four_lane_mode_select,
  output logic      [pcs_lane_pkg::LANE_COUNT-1:0]    o_lane_bip_err,
  output logic                                        o_high_error_rate_flag,
  output logic                                        o_signal_ordered_set_seen,
  output logic      [2:0]                             o_tp_mismatch_incr,
  output logic      [7:0]                             o_received_marker_parity_byte,
  output logic                                        o_received_marker_parity_valid,
  output logic                                        o_internal_local_fault,
  output logic                                        o_four_lane_mode,
  output logic      [pcs_lane_pkg::DATA_W-1:0]        o_tx_data,
  output logic      [7:0]                             o_tx_marker_bip7
);
  import pcs_lane_pkg::*;

  localparam int GROUPS = DATA_W / GROUP_W;
  localparam int WIN_W  = $clog2(BER_WINDOW_CYCLES + 1);
  localparam int ERR_W  = $clog2(BER_ERR_LIMIT + 1);

  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic                  rx_tp_en;
    logic                  tx_tp_en;
    logic                  ovr_en;
    logic [7:0]            ovr_byte;
    logic [LANE_COUNT-1:0] bip_err;
    logic [WIN_W-1:0]      win_cnt;
    logic [ERR_W-1:0]      err_cnt;
    logic                  hi_ber;
    logic                  sig_os;
    logic                  lfault;
    logic [2:0]            mism;
    logic [15:0]           tp_count;
    logic [7:0]            mk_byte;
    logic                  mk_valid;
    logic                  mk_seen;
    logic [7:0]            tx_bip7;
    logic [DATA_W-1:0]     tx_data;
    logic [IRQ_W-1:0]      irq_st;
    logic [IRQ_W-1:0]      irq_mask;
    logic                  irq;
  } state_t;

  state_t            state_reg;
  state_t            state_next;
  logic              four_lane;
  logic [DATA_W-1:0] chk_data;
  logic              chk_valid;
  logic [DATA_W-1:0] gen_data;
  logic              win_end;
  logic              bus_take;
  logic [IRQ_W-1:0]  events;
  logic [2:0]        mism_now;
  logic              ber_rise;

  function automatic logic [2:0] count_bad(input logic [DATA_W-1:0] d);
    logic [3:0] n;
    n = 4'h0;
    for (int g = 0; g < GROUPS; g++) begin
      if (d[g*GROUP_W +: GROUP_W] != IDLE_WORD[g*GROUP_W +: GROUP_W]) begin
        n = n + 4'h1;
      end
    end
    count_bad = (n > 4'h7) ? 3'h7 : n[2:0];
  endfunction : count_bad

  function automatic logic [7:0] reg_offset(input logic [7:0] a);
    reg_offset = {a[7:2], 2'b00};
  endfunction : reg_offset

  //////////////////////////////////////////////////////////////////////////
  // mode pin, pattern checker and generator

  level_sync3 u_mode_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (i_four_lane_mode_select),
    .o_level (four_lane)
  );

  idle_scrambler #(.W(DATA_W), .DESCRAMBLE(1'b1)) u_checker (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_clear (~state_reg.rx_tp_en),
    .i_en    (i_rx_data_valid),
    .i_data  (i_rx_data),
    .o_data  (chk_data),
    .o_valid (chk_valid)
  );

  idle_scrambler #(.W(DATA_W), .DESCRAMBLE(1'b0)) u_generator (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_clear (~state_reg.tx_tp_en),
    .i_en    (1'b1),
    .i_data  (IDLE_WORD),
    .o_data  (gen_data),
    .o_valid ()
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  assign win_end  = (state_reg.win_cnt == WIN_W'(BER_WINDOW_CYCLES - 1));
  assign bus_take = i_wb_cyc & i_wb_stb & ~state_reg.ack;
  // a word is judged only if the checker took it in the cycle before; the first one is judged too
  assign mism_now = chk_valid ? count_bad(chk_data) : 3'h0;
  // rise comes from registered state so no loop runs through next state
  assign ber_rise = win_end & ~state_reg.hi_ber &
                    (state_reg.err_cnt >= ERR_W'(BER_ERR_LIMIT));
  assign events   = {i_rx_marker_seen,
                     (state_reg.mism != 3'h0),
                     ber_rise,
                     i_rx_signal_os_word,
                     (|i_rx_lane_bip_fail)};

  always_comb begin
    state_next          = state_reg;
    state_next.bip_err  = i_rx_lane_bip_fail;
    state_next.sig_os   = i_rx_signal_os_word;

    state_next.win_cnt  = win_end ? '0 : state_reg.win_cnt + WIN_W'(1);
    if (win_end) begin
      state_next.hi_ber  = (state_reg.err_cnt >= ERR_W'(BER_ERR_LIMIT));
      state_next.err_cnt = '0;
    end else if (i_rx_header_err &&
                 state_reg.err_cnt != ERR_W'(BER_ERR_LIMIT)) begin
      state_next.err_cnt = state_reg.err_cnt + ERR_W'(1);
    end

    state_next.mism = state_reg.rx_tp_en ? mism_now : 3'h0;
    // saturating sum of the increments for software
    if (state_reg.tp_count != 16'hFFFF) begin
      state_next.tp_count = state_reg.tp_count + 16'(state_reg.mism);
      if (state_reg.tp_count > 16'hFFFF - 16'(state_reg.mism)) begin
        state_next.tp_count = 16'hFFFF;
      end
    end

    state_next.mk_valid = i_rx_marker_seen;
    state_next.mk_seen  = state_reg.mk_seen | i_rx_marker_seen;
    if (i_rx_marker_seen) begin
      state_next.mk_byte = i_rx_marker_bip7;
    end

    state_next.tx_bip7 = state_reg.ovr_en ? state_reg.ovr_byte
                                          : i_tx_marker_bip7;
    state_next.tx_data = state_reg.tx_tp_en ? gen_data : i_tx_data;
    state_next.lfault  = state_reg.tx_tp_en | state_reg.hi_ber;

    // bus slave: answer one cycle after the request, drop after one
    state_next.ack   = bus_take;
    state_next.rdata = state_reg.rdata;
    if (bus_take && !i_wb_we) begin
      state_next.rdata = 32'h0000_0000;
      case (reg_offset(i_wb_adr))
        OFS_CTRL: begin
          state_next.rdata[CTRL_RX_TP]  = state_reg.rx_tp_en;
          state_next.rdata[CTRL_TX_TP]  = state_reg.tx_tp_en;
          state_next.rdata[CTRL_OVR_EN] = state_reg.ovr_en;
          state_next.rdata[CTRL_OVR_LSB +: 8] = state_reg.ovr_byte;
        end
        OFS_STATUS: begin
          state_next.rdata[ST_HI_BER]    = state_reg.hi_ber;
          state_next.rdata[ST_SIG_OS]    = state_reg.sig_os;
          state_next.rdata[ST_FAULT]     = state_reg.lfault;
          state_next.rdata[ST_FOUR_LANE] = four_lane;
          state_next.rdata[ST_MK_VALID]  = state_reg.mk_seen;
          state_next.rdata[ST_MK_LSB +: 8] = state_reg.mk_byte;
        end
        OFS_IRQ_STAT:  state_next.rdata[IRQ_W-1:0] = state_reg.irq_st;
        OFS_IRQ_MASK:  state_next.rdata[IRQ_W-1:0] = state_reg.irq_mask;
        OFS_ERR_COUNT: state_next.rdata[15:0] = state_reg.tp_count;
        default:       state_next.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_take && i_wb_we) begin
      case (reg_offset(i_wb_adr))
        OFS_CTRL: begin
          if (i_wb_sel[0]) begin
            state_next.rx_tp_en = i_wb_dat[CTRL_RX_TP];
            state_next.tx_tp_en = i_wb_dat[CTRL_TX_TP];
            state_next.ovr_en   = i_wb_dat[CTRL_OVR_EN];
          end
          if (i_wb_sel[1]) begin
            state_next.ovr_byte = i_wb_dat[CTRL_OVR_LSB +: 8];
          end
        end
        OFS_IRQ_MASK: begin
          if (i_wb_sel[0]) begin
            state_next.irq_mask = i_wb_dat[IRQ_W-1:0];
          end
        end
        // a write clears the sum; this cycle's increment still counts
        OFS_ERR_COUNT: state_next.tp_count = 16'(state_reg.mism);
        default: ;
      endcase
    end

    // read clears the sticky bits, but a new event wins over the clear
    state_next.irq_st = state_reg.irq_st;
    if (bus_take && !i_wb_we &&
        reg_offset(i_wb_adr) == OFS_IRQ_STAT) begin
      state_next.irq_st = '0;
    end
    state_next.irq_st = state_next.irq_st | events;
    state_next.irq    = |(state_reg.irq_st & state_reg.irq_mask);
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg          <= '0;
      state_reg.ovr_byte <= OVR_BYTE_RST;
      state_reg.irq_mask <= IRQ_MASK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_wb_dat                       = state_reg.rdata;
  assign o_wb_ack                       = state_reg.ack;
  assign o_irq                          = state_reg.irq;
  assign o_lane_bip_err                 = state_reg.bip_err;
  assign o_high_error_rate_flag         = state_reg.hi_ber;
  assign o_signal_ordered_set_seen      = state_reg.sig_os;
  assign o_tp_mismatch_incr             = state_reg.mism;
  assign o_received_marker_parity_byte  = state_reg.mk_byte;
  assign o_received_marker_parity_valid = state_reg.mk_valid;
  assign o_internal_local_fault         = state_reg.lfault;
  assign o_four_lane_mode               = four_lane;
  assign o_tx_data                      = state_reg.tx_data;
  assign o_tx_marker_bip7               = state_reg.tx_bip7;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  a_bip_lane_pulse: assert property (
    o_lane_bip_err == $past(i_rx_lane_bip_fail))
    else $error("lane parity error output does not follow its lane");

  a_bip_back_to_back: assert property (
    i_rx_lane_bip_fail[0] ##1 i_rx_lane_bip_fail[0] |->
    o_lane_bip_err[0] ##1 o_lane_bip_err[0])
    else $error("back to back lane parity errors merged");

  a_ber_window_only: assert property (
    $changed(o_high_error_rate_flag) |-> $past(win_end))
    else $error("error rate flag moved outside a window end");

  a_sig_os_flag: assert property (
    i_rx_signal_os_word |=> o_signal_ordered_set_seen)
    else $error("ordered-set word not flagged");

  a_mism_gated: assert property (
    !state_reg.rx_tp_en |=> o_tp_mismatch_incr == 3'h0)
    else $error("mismatch increment nonzero while checking is off");

  a_mism_cause: assert property (
    o_tp_mismatch_incr != 3'h0 |-> $past(chk_valid))
    else $error("mismatch increment without checked data");

  a_tx_idle_out: assert property (
    state_reg.tx_tp_en |=> o_tx_data == $past(gen_data))
    else $error("pattern generator not on transmit data");

  a_marker_ovr: assert property (
    state_reg.ovr_en |=> o_tx_marker_bip7 == $past(state_reg.ovr_byte))
    else $error("marker parity byte not overridden");

  a_marker_rx: assert property (
    i_rx_marker_seen |=> o_received_marker_parity_valid &&
    o_received_marker_parity_byte == $past(i_rx_marker_bip7))
    else $error("received marker byte not presented with strobe");

  a_fault_gen: assert property (
    state_reg.tx_tp_en [*2] |-> o_internal_local_fault)
    else $error("local fault low during pattern generation");

  a_mode_stable: assert property (
    $stable(i_four_lane_mode_select) [*6] |->
    o_four_lane_mode == $past(i_four_lane_mode_select, 5))
    else $error("lane mode does not follow a steady pin");

  a_wb_ack_once: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("bus acknowledge longer than one cycle");

  a_wb_answer: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered in the next cycle");

  a_marker_hold: assert property (
    !i_rx_marker_seen |=> $stable(o_received_marker_parity_byte))
    else $error("received marker byte moved without a marker");

  a_marker_strobe: assert property (
    !i_rx_marker_seen |=> !o_received_marker_parity_valid)
    else $error("marker valid strobe without a marker");

  a_mism_range: assert property (
    o_tp_mismatch_incr <= 3'(GROUPS))
    else $error("mismatch increment above the group count");

  a_fault_ber: assert property (
    o_high_error_rate_flag |=> o_internal_local_fault)
    else $error("local fault low during high error rate");

  c_bip_pulse:   cover property (o_lane_bip_err != '0);
  c_mismatch:    cover property (o_tp_mismatch_incr != 3'h0);
  c_hi_ber:      cover property ($rose(o_high_error_rate_flag));
  c_irq:         cover property ($rose(o_irq));
  c_marker:      cover property (o_received_marker_parity_valid);
endmodule : pcs_lane_test_and_marker_status
